// *** src/dmode_pkg.sv ***
/*
 * Constants for the display mode control register bank: register offset,
 * field positions, reset values and pixel path widths.
 * Assumes a single core clock domain; included by import only.
 */
package dmode_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int          ADDR_W        = 12;
	localparam int          REG_W         = 16;
	localparam logic [11:0] OFS_DMODE0    = 12'h830;
	localparam logic [11:0] OFS_OVL1_YPOS = 12'h84E; // Not in this block
	localparam logic [15:0] DMODE0_RST    = 16'h0000;

	// ------------------------------------------------------------------
	// Field positions of display_mode_setting_0
	// ------------------------------------------------------------------
	localparam int BIT_HDBL      = 15;
	localparam int BIT_MAN_SEL   = 13;
	localparam int BIT_BUF_STAT  = 12;
	localparam int BIT_MODE_HI   = 10;
	localparam int BIT_MODE_LO   = 8;
	localparam int BIT_SWRST     = 7;
	localparam int BIT_BLANK     = 6;
	localparam int BIT_INVERT    = 5;
	localparam int BIT_RSVD      = 4;
	localparam int BIT_OUT_STAT  = 2;
	localparam int BIT_OUT_EN    = 0;

	// ------------------------------------------------------------------
	// Field encodings
	// ------------------------------------------------------------------
	localparam logic [2:0] MODE_MAIN      = 3'h0;
	localparam logic [2:0] MODE_OVL1      = 3'h1;
	localparam logic [2:0] MODE_OVL2      = 3'h2;
	localparam logic [2:0] MODE_BOTH      = 3'h3;
	localparam logic [1:0] SRC_SPRITE     = 2'h0;
	localparam logic       RSVD_RST       = 1'h0;

	// ------------------------------------------------------------------
	// Pixel path widths
	// ------------------------------------------------------------------
	localparam int DATA_W = 24;
	localparam int CTRL_W = 3;

endpackage : dmode_pkg

// *** src/lcd_display_mode_control.sv ***
/*
 * Display mode control register with its pixel output stage: window
 * composition decode, buffer selection, blank, invert, doubling,
 * output enable and a self-clearing software reset.
 * Assumes all inputs come from logic on core_clk; the register port is
 * a plain strobe port with read data one cycle after the read strobe.
 */
// Notes on behaviour
// [R1] Doubling bit doubles pixels, only with YUV
// [R2] Manual bit picks front or back buffer
// [R3] Manual bit ignored under double buffering
// [R4] Status bit shows displayed buffer
// [R5] Status valid under double buffering only for sprites
// [R6] Mode field selects main and overlay windows
// [R7] Host changes mode only in non-display period
// [R8] Host zeroes first overlay start before disabling
// [R9] Writing one resets module, pins and registers
// [R10] Writing zero to reset bit does nothing
// [R11] Blank forces all data outputs low
// [R12] Invert flips data outputs, controls untouched
// [R13] Blank takes priority over invert
// [R14] Reserved bit four stays zero
// [R15] Output status reads one while output active
// [R16] Host configures shared pins before enabling
// [R17] Output driven only while enable bit set
// [R18] Reset bit self-clears, reads zero
`timescale 1ns/1ps
module lcd_display_mode_control
	import dmode_pkg::*;
(
	input  wire logic              core_clk,    // Core clock, 250 MHz
	input  wire logic              arst_n,      // Async reset, active low
	input  wire logic [ADDR_W-1:0] reg_addr,    // Register byte address
	input  wire logic [REG_W-1:0]  reg_wdata,   // Write data
	input  wire logic              reg_wr,      // Write strobe
	input  wire logic              reg_rd,      // Read strobe
	output logic      [REG_W-1:0]  reg_rdata,   // Read data, next cycle
	input  wire logic              yuv_sel,     // YUV interface selected
	input  wire logic              dbuf_en,     // Double buffering on
	input  wire logic [1:0]        dbuf_src,    // Double buffer source
	input  wire logic              engine_buf,  // Buffer shown by engine
	input  wire logic [DATA_W-1:0] pix_data,    // Pixel data in
	input  wire logic [CTRL_W-1:0] pix_ctrl,    // Control in, [0] is DE
	output logic      [DATA_W-1:0] disp_data,   // Display data out
	output logic      [CTRL_W-1:0] disp_ctrl,   // Display controls out
	output logic                   disp_oe,     // Output enable
	output logic                   buf_shown,   // Buffer being shown
	output logic                   ovl1_en,     // First overlay shown
	output logic                   ovl2_en,     // Second overlay shown
	output logic                   lcd_reset    // Module reset pulse
);

	// ------------------------------------------------------------------
	// Register fields
	// ------------------------------------------------------------------
	logic       hdbl_ff,    nxt_hdbl;
	logic       man_sel_ff, nxt_man_sel;
	logic [2:0] mode_ff,    nxt_mode;
	logic       blank_ff,   nxt_blank;
	logic       invert_ff,  nxt_invert;
	logic       out_en_ff,  nxt_out_en;
	logic       swrst_ff,   nxt_swrst;
	logic       wr_hit;
	logic       rd_hit;

	assign wr_hit = reg_wr && (reg_addr == OFS_DMODE0);
	assign rd_hit = reg_rd && (reg_addr == OFS_DMODE0);

	// Software reset returns every field to default next cycle
	always_comb begin
		nxt_hdbl    = hdbl_ff;
		nxt_man_sel = man_sel_ff;
		nxt_mode    = mode_ff;
		nxt_blank   = blank_ff;
		nxt_invert  = invert_ff;
		nxt_out_en  = out_en_ff;
		nxt_swrst   = 1'b0;                              // [R18]
		if (swrst_ff) begin
			nxt_hdbl    = DMODE0_RST[BIT_HDBL];           // [R9]
			nxt_man_sel = DMODE0_RST[BIT_MAN_SEL];
			nxt_mode    = DMODE0_RST[BIT_MODE_HI:BIT_MODE_LO];
			nxt_blank   = DMODE0_RST[BIT_BLANK];
			nxt_invert  = DMODE0_RST[BIT_INVERT];
			nxt_out_en  = DMODE0_RST[BIT_OUT_EN];
		end else if (wr_hit) begin
			nxt_hdbl    = reg_wdata[BIT_HDBL];
			nxt_man_sel = reg_wdata[BIT_MAN_SEL];
			nxt_mode    = reg_wdata[BIT_MODE_HI:BIT_MODE_LO];
			nxt_blank   = reg_wdata[BIT_BLANK];
			nxt_invert  = reg_wdata[BIT_INVERT];
			nxt_out_en  = reg_wdata[BIT_OUT_EN];
			nxt_swrst   = reg_wdata[BIT_SWRST];           // [R9] [R10]
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hdbl_ff    <= DMODE0_RST[BIT_HDBL];
			man_sel_ff <= DMODE0_RST[BIT_MAN_SEL];
			mode_ff    <= DMODE0_RST[BIT_MODE_HI:BIT_MODE_LO];
			blank_ff   <= DMODE0_RST[BIT_BLANK];
			invert_ff  <= DMODE0_RST[BIT_INVERT];
			out_en_ff  <= DMODE0_RST[BIT_OUT_EN];
			swrst_ff   <= 1'b0;
		end else begin
			hdbl_ff    <= nxt_hdbl;
			man_sel_ff <= nxt_man_sel;
			mode_ff    <= nxt_mode;
			blank_ff   <= nxt_blank;
			invert_ff  <= nxt_invert;
			out_en_ff  <= nxt_out_en;
			swrst_ff   <= nxt_swrst;
		end
	end

	// ------------------------------------------------------------------
	// Decoded state: windows, buffer, output status
	// ------------------------------------------------------------------
	logic       ovl1_ff, nxt_ovl1;
	logic       ovl2_ff, nxt_ovl2;
	logic       buf_ff,  nxt_buf;
	logic       oe_ff,   nxt_oe;

	always_comb begin
		// Reserved mode codes fall back to the main window alone
		case (mode_ff)                                  // [R6]
			MODE_MAIN: begin
				nxt_ovl1 = 1'b0;
				nxt_ovl2 = 1'b0;
			end
			MODE_OVL1: begin
				nxt_ovl1 = 1'b1;
				nxt_ovl2 = 1'b0;
			end
			MODE_OVL2: begin
				nxt_ovl1 = 1'b0;
				nxt_ovl2 = 1'b1;
			end
			MODE_BOTH: begin
				nxt_ovl1 = 1'b1;
				nxt_ovl2 = 1'b1;
			end
			default: begin
				nxt_ovl1 = 1'b0;
				nxt_ovl2 = 1'b0;
			end
		endcase
		// Engine view is only meaningful when sprites are the source
		if (!dbuf_en)
			nxt_buf = man_sel_ff;                        // [R2] [R4]
		else if (dbuf_src == SRC_SPRITE)
			nxt_buf = engine_buf;                        // [R3] [R5]
		else
			nxt_buf = 1'b0;
		nxt_oe = out_en_ff && !swrst_ff;                 // [R17] [R9]
		if (swrst_ff) begin
			nxt_ovl1 = 1'b0;
			nxt_ovl2 = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ovl1_ff <= 1'b0;
			ovl2_ff <= 1'b0;
			buf_ff  <= 1'b0;
			oe_ff   <= 1'b0;
		end else begin
			ovl1_ff <= nxt_ovl1;
			ovl2_ff <= nxt_ovl2;
			buf_ff  <= nxt_buf;
			oe_ff   <= nxt_oe;
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic [REG_W-1:0] rdata_ff, nxt_rdata;

	// Reset bit and reserved bit always read zero
	always_comb begin
		nxt_rdata = '0;
		if (rd_hit) begin
			nxt_rdata[BIT_HDBL]                = hdbl_ff;
			nxt_rdata[BIT_MAN_SEL]             = man_sel_ff;
			nxt_rdata[BIT_BUF_STAT]            = buf_ff;   // [R4]
			nxt_rdata[BIT_MODE_HI:BIT_MODE_LO] = mode_ff;
			nxt_rdata[BIT_BLANK]               = blank_ff;
			nxt_rdata[BIT_INVERT]              = invert_ff;
			nxt_rdata[BIT_RSVD]                = RSVD_RST; // [R14]
			nxt_rdata[BIT_OUT_STAT]            = oe_ff;    // [R15]
			nxt_rdata[BIT_OUT_EN]              = out_en_ff;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rdata_ff <= '0;
		else
			rdata_ff <= nxt_rdata;
	end

	// ------------------------------------------------------------------
	// Pixel path; controls delayed to match the shaper flop
	// ------------------------------------------------------------------
	pix_if px ();
	logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;

	assign px.oe     = out_en_ff && !swrst_ff;
	assign px.blank  = blank_ff;
	assign px.invert = invert_ff;
	assign px.dbl    = hdbl_ff && yuv_sel;               // [R1]
	assign px.de     = pix_ctrl[0];
	assign px.din    = pix_data;

	pixel_shaper u_shaper (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.px       (px.shp)
	);

	// Controls bypass blank and invert, only the enable and software reset gate them
	always_comb begin
		nxt_ctrl = (out_en_ff && !swrst_ff) ? pix_ctrl : '0;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			ctrl_ff <= '0;
		else
			ctrl_ff <= nxt_ctrl;
	end

	assign reg_rdata = rdata_ff;
	assign disp_data = px.dout;
	assign disp_ctrl = ctrl_ff;
	assign disp_oe   = oe_ff;
	assign buf_shown = buf_ff;
	assign ovl1_en   = ovl1_ff;
	assign ovl2_en   = ovl2_ff;
	assign lcd_reset = swrst_ff;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_blank_data_low: assert property ( // [R11]
		out_en_ff && blank_ff && !swrst_ff |=> disp_data == '0)
		else $error("blanked data not low");
	a_invert_data_flip: assert property ( // [R12]
		out_en_ff && invert_ff && !blank_ff && !hdbl_ff && !swrst_ff
		|=> disp_data == ~$past(pix_data))
		else $error("inverted data wrong");
	a_blank_over_inv: assert property ( // [R13]
		out_en_ff && blank_ff && invert_ff && !swrst_ff
		|=> disp_data == '0)
		else $error("invert acted under blank");
	a_manual_buf_sel: assert property ( // [R2]
		!dbuf_en |=> buf_shown == $past(man_sel_ff))
		else $error("manual buffer not shown");
	a_dbuf_ignores_man: assert property ( // [R3]
		dbuf_en && dbuf_src == SRC_SPRITE |=> buf_shown == $past(engine_buf))
		else $error("manual select leaked");
	a_mode_both_ovl: assert property ( // [R6]
		mode_ff == MODE_BOTH && !swrst_ff |=> ovl1_en && ovl2_en)
		else $error("mode decode wrong");
	a_swrst_defaults: assert property ( // [R9]
		lcd_reset |=> mode_ff == 3'h0 && !out_en_ff && !blank_ff
		##1 !disp_oe)
		else $error("software reset left state");
	a_swrst_one_pulse: assert property ( // [R18]
		wr_hit && reg_wdata[BIT_SWRST] && !swrst_ff
		|=> lcd_reset ##1 !lcd_reset)
		else $error("reset pulse not one cycle");
	a_zero_no_reset: assert property ( // [R10]
		wr_hit && !reg_wdata[BIT_SWRST] |=> !lcd_reset)
		else $error("zero write caused reset");
	a_status_reads_oe: assert property ( // [R15]
		rd_hit |=> reg_rdata[BIT_OUT_STAT] == $past(disp_oe)
		&& reg_rdata[BIT_SWRST] == 1'b0 && reg_rdata[BIT_RSVD] == 1'b0)
		else $error("status readback wrong");
	a_disabled_no_out: assert property ( // [R17]
		!out_en_ff |=> !disp_oe && disp_data == '0 && disp_ctrl == '0)
		else $error("output while disabled");
	a_reserved_no_ovl: assert property ( // [R6]
		mode_ff[2] |=> !ovl1_en && !ovl2_en)
		else $error("reserved mode showed overlay");
	a_buf_status_rd: assert property ( // [R4]
		rd_hit |=> reg_rdata[BIT_BUF_STAT] == $past(buf_shown))
		else $error("buffer status readback wrong");
	a_ctrl_not_shaped: assert property ( // [R12]
		out_en_ff && !swrst_ff |=> disp_ctrl == $past(pix_ctrl))
		else $error("controls altered by data shaping");
	// Odd phase must repeat the pixel taken on the even phase
	a_double_repeat: assert property ( // [R1]
		px.dbl && pix_ctrl[0] && !u_shaper.phase_ff ##1
		px.dbl && px.oe && !blank_ff && !invert_ff
		|=> disp_data == $past(pix_data, 2))
		else $error("doubled pixel not repeated");

	c_blank_seen:  cover property (out_en_ff && blank_ff ##1 disp_oe);
	c_double_seen: cover property ((px.dbl && pix_ctrl[0]) [*4]);
	c_swrst_seen:  cover property (wr_hit ##1 lcd_reset);
	c_both_ovl:    cover property (ovl1_en && ovl2_en);

endmodule : lcd_display_mode_control

// *** src/pix_if.sv ***
/*
 * Carrier between the register bank and the pixel shaper.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface pix_if;
	import dmode_pkg::*;

	logic              oe;       // Output enabled and not in reset
	logic              blank;    // Force data low
	logic              invert;   // Invert data
	logic              dbl;      // Horizontal doubling active
	logic              de;       // Data enable of incoming pixel
	logic [DATA_W-1:0] din;      // Incoming pixel
	logic [DATA_W-1:0] dout;     // Shaped pixel, registered

	modport ctl (output oe, blank, invert, dbl, de, din, input dout);
	modport shp (input oe, blank, invert, dbl, de, din, output dout);
endinterface : pix_if

// *** src/pixel_shaper.sv ***
/*
 * Pixel shaper: horizontal doubling, blanking and inversion of the
 * display data, registered once.
 * Assumes the upstream source supplies pixels at half rate while
 * doubling is active; control signals are delayed by the caller.
 */
`timescale 1ns/1ps
module pixel_shaper
	import dmode_pkg::*;
(
	input  wire logic core_clk,   // Core clock
	input  wire logic arst_n,     // Async reset, active low
	pix_if.shp        px          // Pixel carrier
);

	logic              phase_ff;
	logic              nxt_phase;
	logic [DATA_W-1:0] hold_ff;
	logic [DATA_W-1:0] nxt_hold;
	logic [DATA_W-1:0] dout_ff;
	logic [DATA_W-1:0] nxt_dout;
	logic [DATA_W-1:0] src;

	// ------------------------------------------------------------------
	// Next pixel: doubling picks the held copy on odd phase
	// ------------------------------------------------------------------
	always_comb begin
		nxt_phase = phase_ff;
		nxt_hold  = hold_ff;
		if (px.dbl && px.de) begin
			nxt_phase = ~phase_ff;
			if (!phase_ff)
				nxt_hold = px.din;
		end else if (!px.dbl) begin
			nxt_phase = 1'b0;
		end
		src = (px.dbl && phase_ff) ? hold_ff : px.din;  // [R1]
		// Blank wins over invert, so it is tested first
		if (!px.oe)
			nxt_dout = '0;                 // [R17]
		else if (px.blank)
			nxt_dout = '0;                 // [R11] [R13]
		else if (px.invert)
			nxt_dout = ~src;               // [R12]
		else
			nxt_dout = src;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_ff <= 1'b0;
			hold_ff  <= '0;
			dout_ff  <= '0;
		end else begin
			phase_ff <= nxt_phase;
			hold_ff  <= nxt_hold;
			dout_ff  <= nxt_dout;
		end
	end

	assign px.dout = dout_ff;

endmodule : pixel_shaper

// *** tb/lcd_display_mode_control_tb_top.sv ***
/*
 * Self-checking bench for the display mode register and pixel stage.
 * Assumes the package, design sources and the panel sink are compiled
 * first; all inputs are driven on the core clock.
 */
`timescale 1ns/1ps
module lcd_display_mode_control_tb_top;
	import dmode_pkg::*;

	// ----------------------------------------------------------------
	// Signals and bench state
	// ----------------------------------------------------------------
	logic              core_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [REG_W-1:0]  reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic              yuv_sel = 1'b0;
	logic              dbuf_en = 1'b0;
	logic [1:0]        dbuf_src = '0;
	logic              engine_buf = 1'b0;
	logic [DATA_W-1:0] pix_data = '0;
	logic [CTRL_W-1:0] pix_ctrl = '0;
	logic [REG_W-1:0]  reg_rdata;
	logic [DATA_W-1:0] disp_data;
	logic [CTRL_W-1:0] disp_ctrl;
	logic              disp_oe, buf_shown, ovl1_en, ovl2_en, lcd_reset;
	logic [15:0]       pix_seen;
	logic              idle_fault;
	logic              pin_mux_lcd = 1'b0;
	logic [15:0]       cur_w = '0;
	int                errors = 0;
	int                total_checks = 0;
	int                seed = 25;
	int                exp_pix = 0;

	always #2 core_clk = ~core_clk;

	lcd_display_mode_control dut (.core_clk(core_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .yuv_sel(yuv_sel),
		.dbuf_en(dbuf_en), .dbuf_src(dbuf_src), .engine_buf(engine_buf),
		.pix_data(pix_data), .pix_ctrl(pix_ctrl), .disp_data(disp_data),
		.disp_ctrl(disp_ctrl), .disp_oe(disp_oe), .buf_shown(buf_shown),
		.ovl1_en(ovl1_en), .ovl2_en(ovl2_en), .lcd_reset(lcd_reset));

	panel_sink sink (.core_clk(core_clk), .arst_n(arst_n),
		.disp_data(disp_data), .disp_ctrl(disp_ctrl), .disp_oe(disp_oe),
		.pin_mux_lcd(pin_mux_lcd), .pix_seen(pix_seen),
		.idle_fault(idle_fault));

	// ----------------------------------------------------------------
	// Checking and expectations
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// Status only trusted for the sprite source under double buffering
	function automatic logic bufx();
		if (dbuf_en)
			return (dbuf_src == SRC_SPRITE) ? engine_buf : 1'b0;
		return cur_w[BIT_MAN_SEL];
	endfunction : bufx

	// Writable bits echo; reset bit and reserved bit read zero
	function automatic logic [15:0] rdx();
		return (cur_w & 16'hA761) | (16'(bufx()) << BIT_BUF_STAT)
			| (16'(cur_w[BIT_OUT_EN]) << BIT_OUT_STAT);
	endfunction : rdx

	function automatic logic [1:0] ovlx(input logic [2:0] m);
		return {m == 3'h2 || m == 3'h3, m == 3'h1 || m == 3'h3};
	endfunction : ovlx

	// ----------------------------------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------------------------------
	// One-cycle strobe; returns just after the edge that takes it
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask : bus

	// Even pixel count keeps the doubling phase aligned between runs
	task automatic stream();
		logic [DATA_W-1:0] pd, npd, held, xd;
		logic [CTRL_W-1:0] pc, npc;
		logic              ph, dbl;
		ph = 1'b0;
		dbl = cur_w[BIT_HDBL] & yuv_sel;
		for (int k = 0; k <= 8; k++) begin
			@(posedge core_clk);
			npd = DATA_W'($random(seed));
			npc = {2'($random(seed)), 1'b1};
			pix_data <= npd;
			pix_ctrl <= (k < 8) ? npc : '0;
			#1;
			if (k > 0) begin
				xd = (dbl && ph) ? held : pd;
				held = xd;
				ph = dbl ? !ph : 1'b0;
				xd = cur_w[BIT_BLANK] ? '0 : cur_w[BIT_INVERT] ? ~xd : xd;
				check(disp_data, cur_w[0] ? xd : '0);
				check(disp_ctrl, cur_w[0] ? pc : '0);
			end
			pd = npd;
			pc = npc;
		end
		if (cur_w[0])
			exp_pix += 8;
	endtask : stream

	task automatic cfg(input logic [15:0] w, input logic y, input logic e,
		input logic [1:0] s, input logic b);
		@(posedge core_clk);
		yuv_sel <= y;
		dbuf_en <= e;
		dbuf_src <= s;
		engine_buf <= b;
		bus(1'b1, OFS_OVL1_YPOS, 16'h0000);
		bus(1'b1, OFS_DMODE0, w); // data enable is low here
		check(lcd_reset, 1'b0);
		cur_w = w;
		repeat (3) @(posedge core_clk);
		#1;
		check(disp_oe, w[BIT_OUT_EN]);
		check(buf_shown, bufx());
		check({ovl2_en, ovl1_en}, ovlx(w[10:8]));
		bus(1'b0, OFS_DMODE0, '0);
		check(reg_rdata, rdx());
		stream();
	endtask : cfg

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		pin_mux_lcd <= 1'b1; // before any output enable
		bus(1'b0, OFS_DMODE0, '0);
		check(reg_rdata, DMODE0_RST);
		// Every mode code, reserved ones among them
		for (int m = 0; m < 8; m++)
			cfg(16'h0001 | (16'(m) << 8), 1'b0, 1'b0, 2'h0, 1'b0);
		cfg(16'h0021, 1'b0, 1'b0, 2'h0, 1'b0);
		cfg(16'h0041, 1'b0, 1'b0, 2'h0, 1'b0);
		cfg(16'h0061, 1'b0, 1'b0, 2'h0, 1'b0);
		cfg(16'h8001, 1'b1, 1'b0, 2'h0, 1'b0);
		cfg(16'h8001, 1'b0, 1'b0, 2'h0, 1'b0);
		cfg(16'h2001, 1'b0, 1'b0, 2'h0, 1'b0);
		cfg(16'h2001, 1'b0, 1'b1, 2'h0, 1'b0);
		cfg(16'h0001, 1'b0, 1'b1, 2'h1, 1'b1);
		cfg(16'hFF7F, 1'b1, 1'b1, 2'h0, 1'b1);
		// Unmapped neighbour: write ignored, read returns zero
		bus(1'b1, 12'h832, 16'h0000);
		bus(1'b0, 12'h832, '0);
		check(reg_rdata, 16'h0000);
		bus(1'b0, OFS_DMODE0, '0);
		check(reg_rdata, rdx());
		// Software reset from a busy setting
		cfg(16'hA761, 1'b0, 1'b0, 2'h0, 1'b0);
		bus(1'b1, OFS_DMODE0, 16'h00E1);
		check(lcd_reset, 1'b1);
		@(posedge core_clk);
		#1;
		check(lcd_reset, 1'b0);
		cur_w = '0;
		repeat (2) @(posedge core_clk);
		#1;
		check(disp_oe, 1'b0);
		bus(1'b0, OFS_DMODE0, '0);
		check(reg_rdata, rdx());
		stream();
		// Random settings, reset bit kept clear
		for (int i = 0; i < 24; i++)
			cfg(16'($random(seed)) & 16'hFF7F, 1'($random(seed)),
				1'($random(seed)), 2'($random(seed)), 1'($random(seed)));
		@(posedge core_clk);
		#1;
		check(pix_seen, 16'(exp_pix));
		check(idle_fault, 1'b0);
		tally_and_finish();
	end

	// Whole run needs well under 20000 cycles
	initial begin
		#80000;
		errors++;
		tally_and_finish();
	end
endmodule : lcd_display_mode_control_tb_top

// *** tb/panel_sink.sv ***
/*
 * Behavioural panel sink on the display pins: counts the pixels it
 * latches and flags any pin activity while the pins are not driven.
 * Assumes the panel samples the pins on the core clock.
 */
`timescale 1ns/1ps
module panel_sink
	import dmode_pkg::*;
(
	input  wire logic              core_clk,   // Core clock
	input  wire logic              arst_n,     // Async reset, active low
	input  wire logic [DATA_W-1:0] disp_data,  // Display data pins
	input  wire logic [CTRL_W-1:0] disp_ctrl,  // Display control pins
	input  wire logic              disp_oe,    // Pins driven
	input  wire logic              pin_mux_lcd, // Shared pins given to LCD
	output logic      [15:0]       pix_seen,   // Pixels latched
	output logic                   idle_fault  // Activity while undriven
);
	// ----------------------------------------------------------------
	// Pixel capture
	// ----------------------------------------------------------------
	// A panel only latches on data enable while the pins are driven
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pix_seen <= '0;
			idle_fault <= 1'b0;
		end else begin
			if (disp_oe && disp_ctrl[0])
				pix_seen <= pix_seen + 16'h1;
			if (!disp_oe && (disp_data !== '0 || disp_ctrl !== '0))
				idle_fault <= 1'b1;
			// Driving pins still owned by another function would clash
			if (disp_oe && !pin_mux_lcd)
				idle_fault <= 1'b1;
		end
	end
endmodule : panel_sink
